// [src/rtcp_pkg.sv]
package rtcp_pkg;

   // own 7-bit bus address and direction encodings
   localparam logic [6:0] DEV_ADDR = 7'h68;
   localparam logic DIR_WRITE = 1'h0;
   localparam logic DIR_READ = 1'h1;

   // register pointer span and reset value
   localparam logic [5:0] PTR_TOP = 6'h3f;
   localparam logic [5:0] PTR_FIRST = 6'h00;
   localparam logic [5:0] PTR_RST = 6'h00;

   // index of the last data bit inside a byte
   localparam logic [2:0] LAST_BIT = 3'h7;

   // idle level of the synchroniser chains (bus pulled high)
   localparam logic [2:0] SYNC_IDLE = 3'h7;

   // standard-mode bus rate and the link clock period
   localparam int STD_MODE_KHZ = 100;
   localparam int LINK_PERIOD_NS = 30;
   // shortest half period of the serial clock, rounded down
   localparam int SCL_HALF_NS = 1000000 / (2 * STD_MODE_KHZ);
   // link cycles in which a byte fetch must complete
   localparam int SCL_HALF_CYC = SCL_HALF_NS / LINK_PERIOD_NS;

   // one access to the byte-wide register space
   typedef struct packed {
      logic we;
      logic [5:0] addr;
      logic [7:0] wdata;
   } rtcp_acc_t;

   // link-side protocol states
   typedef enum {
      st_idle,
      st_addr,
      st_addr_ack,
      st_ptr,
      st_ptr_ack,
      st_wdata,
      st_wdata_ack,
      st_rdata,
      st_rack
   } rtcp_state_t;

   // pointer advance with wrap from the top of ram back to zero
   function automatic logic [5:0] rtcp_ptr_next(input logic [5:0] p);
      return (p == PTR_TOP) ? PTR_FIRST : p + 6'h01;
   endfunction

   // states in which the device returns an acknowledge
   function automatic logic rtcp_is_ack(input rtcp_state_t s);
      return (s == st_addr_ack) || (s == st_ptr_ack) || (s == st_wdata_ack);
   endfunction

   // states in which the device shifts bits in
   function automatic logic rtcp_is_rx(input rtcp_state_t s);
      return (s == st_addr) || (s == st_ptr) || (s == st_wdata);
   endfunction

endpackage

// [src/rtcp_hs_xfer.sv]
`timescale 1ns/1ps
module rtcp_hs_xfer
(
   // common reset
   input wire logic i_rst_b,
   // link (source) domain
   input wire logic i_src_clock,
   input wire logic i_src_valid,
   input wire rtcp_pkg::rtcp_acc_t i_src_req,
   output logic o_src_busy,
   output logic o_src_done,
   output logic [7:0] o_src_rdata,
   // system (destination) domain
   input wire logic i_dst_clock,
   output logic o_dst_valid,
   output rtcp_pkg::rtcp_acc_t o_dst_acc,
   input wire logic [7:0] i_dst_rdata
);

   logic req_tgl_q; // flips once per request
   rtcp_pkg::rtcp_acc_t req_q; // payload, stable until the answer returns
   logic [2:0] ack_sync_q; // ack toggle seen in the source domain
   logic [2:0] req_sync_q; // req toggle seen in the destination domain
   logic ack_tgl_q; // flips once per answer
   logic [7:0] rsp_q; // read byte, stable while the answer crosses

   // source: launch a request; a request while busy is dropped, the
   // protocol spaces them far wider than one round trip
   always_ff @(posedge i_src_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         req_tgl_q <= 1'b0;
         req_q <= '0;
      end
      else if (i_src_valid && !o_src_busy)
      begin
         req_tgl_q <= ~req_tgl_q;
         req_q <= i_src_req;
      end
   end

   // source: bring the answer toggle home, capture the returned byte
   always_ff @(posedge i_src_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ack_sync_q <= 3'h0;
         o_src_done <= 1'b0;
         o_src_rdata <= 8'h00;
      end
      else
      begin
         ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
         o_src_done <= ack_sync_q[1] ^ ack_sync_q[2];
         if (ack_sync_q[1] ^ ack_sync_q[2])
         begin
            o_src_rdata <= rsp_q;
         end
      end
   end

   // busy from launch until the answer edge has been seen
   assign o_src_busy = req_tgl_q ^ ack_sync_q[2];

   // destination: present each request for one cycle, answer at once
   always_ff @(posedge i_dst_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         req_sync_q <= 3'h0;
         o_dst_valid <= 1'b0;
         o_dst_acc <= '0;
         rsp_q <= 8'h00;
         ack_tgl_q <= 1'b0;
      end
      else
      begin
         req_sync_q <= {req_sync_q[1:0], req_tgl_q};
         o_dst_valid <= req_sync_q[1] ^ req_sync_q[2];
         if (req_sync_q[1] ^ req_sync_q[2])
         begin
            o_dst_acc <= req_q;
         end
         // read data is taken in the cycle the access is shown
         if (o_dst_valid)
         begin
            rsp_q <= i_dst_rdata;
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // every access reaches the user port as a single-cycle pulse
   chk_access_pulse: assert property ( // [R14]
      @(posedge i_dst_clock) disable iff (!i_rst_b)
      o_dst_valid |=> !o_dst_valid)
      else $error("access strobe longer than one cycle");

endmodule

// [src/rtcp_i2c_slave.sv]
`timescale 1ns/1ps
// Summary of operation
// (R01) transfers open with start, close with stop
// (R02) eight-bit bytes, ninth clock carries acknowledge
// (R03) master clocks the bus at 100 kHz maximum
// (R04) acknowledge every byte received once addressed
// (R05) master supplies an extra acknowledge clock
// (R06) hold data low through acknowledge high phase
// (R07) release data after master's final not-acknowledge
// (R08) master acknowledges all read bytes but last
// (R09) bytes travel most significant bit first
// (R10) master alone makes clocks, start and stop
// (R11) repeated start ends and begins a transfer
// (R12) first byte is address; write direction 0
// (R13) write: next byte loads the register pointer
// (R14) store data bytes, advancing pointer each time
// (R15) master ends writes with a stop
// (R16) address with direction 1 enters read mode
// (R17) read starts at the current pointer value
// (R18) pointer advances after each transmitted byte
// (R19) reads continue until master not-acknowledges
// (R20) start and stop recognised in any state
// (R21) pointer wraps from top of ram to zero
// (R22) start: data falls while clock high
// (R23) stop: data rises while clock high
// (R24) foreign address: no acknowledge, wait for start
module rtcp_i2c_slave
(
   // system side
   input wire logic i_clock,
   input wire logic i_rst_b,
   // serial link
   input wire logic i_link_clock,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // register space access, system domain
   output logic o_acc_valid,
   output rtcp_pkg::rtcp_acc_t o_acc,
   input wire logic [7:0] i_acc_rdata
);

   // fetch bound as a plain int for the delay range below
   localparam int FETCH_MAX = rtcp_pkg::SCL_HALF_CYC;

   logic [2:0] scl_q; // clock line synchroniser plus history
   logic [2:0] sda_q; // data line synchroniser plus history
   rtcp_pkg::rtcp_state_t st_q; // protocol state
   rtcp_pkg::rtcp_state_t st_d;
   logic ph_q; // second half of an acknowledge slot
   logic ph_d;
   logic [2:0] bit_q; // bit index within the byte
   logic [2:0] bit_d;
   logic [7:0] sh_q; // receive shifter
   logic [7:0] tx_q; // transmit shifter
   logic dir_q; // direction bit of the last address hit
   logic [5:0] ptr_q; // register pointer
   logic oe_q; // open-drain pull-down
   // decoded link events
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic rx_bit;
   logic [7:0] byte_in;
   logic byte_done;
   logic addr_hit;
   logic wr_byte;
   logic ack_end;
   logic tx_done;
   logic m_ack;
   logic m_nack;
   logic load_tx;
   // crossing to the register space
   logic hs_valid;
   rtcp_pkg::rtcp_acc_t hs_req;
   logic hs_busy;
   logic [7:0] rd_byte;

   // two flops before any logic; the third stage is only history
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         scl_q <= rtcp_pkg::SYNC_IDLE;
         sda_q <= rtcp_pkg::SYNC_IDLE;
      end
      else
      begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda};
      end
   end

   // edges of the clock line, seen on the synchronised copy
   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   // bus conditions, data moving while clock stays high
   assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1]; // [R22]
   assign stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1]; // [R23]
   assign rx_bit = sda_q[1];
   // new bits enter at the bottom, so the first bit ends up on top
   assign byte_in = {sh_q[6:0], rx_bit}; // [R09]

   // byte and slot events
   assign byte_done = rtcp_pkg::rtcp_is_rx(st_q) && scl_rise
                      && (bit_q == rtcp_pkg::LAST_BIT); // [R02]
   assign addr_hit = (st_q == rtcp_pkg::st_addr) && byte_done
                     && (byte_in[7:1] == rtcp_pkg::DEV_ADDR); // [R12] [R16]
   assign wr_byte = (st_q == rtcp_pkg::st_wdata) && byte_done;
   assign ack_end = rtcp_pkg::rtcp_is_ack(st_q) && scl_fall && ph_q;
   assign tx_done = (st_q == rtcp_pkg::st_rdata) && scl_rise
                    && (bit_q == rtcp_pkg::LAST_BIT);
   assign m_ack = (st_q == rtcp_pkg::st_rack) && scl_rise && !rx_bit;
   assign m_nack = (st_q == rtcp_pkg::st_rack) && scl_rise && rx_bit;
   // a fresh byte goes out on the fall that closes an acknowledge slot
   assign load_tx = ((st_q == rtcp_pkg::st_addr_ack) && ack_end && dir_q)
                    || ((st_q == rtcp_pkg::st_rack) && scl_fall && ph_q);

   // next state; start and stop win over anything else
   always_comb
   begin
      st_d = st_q;
      if (start_det)
      begin
         st_d = rtcp_pkg::st_addr; // [R20] [R11] [R01]
      end
      else if (stop_det)
      begin
         st_d = rtcp_pkg::st_idle; // [R20] [R01]
      end
      else
      begin
         case (st_q)
            rtcp_pkg::st_addr:
            begin
               // a foreign address falls back to idle until a start
               if (byte_done)
               begin
                  st_d = addr_hit ? rtcp_pkg::st_addr_ack : rtcp_pkg::st_idle; // [R24]
               end
            end
            rtcp_pkg::st_addr_ack:
            begin
               if (ack_end)
               begin
                  st_d = dir_q ? rtcp_pkg::st_rdata : rtcp_pkg::st_ptr; // [R16] [R13]
               end
            end
            rtcp_pkg::st_ptr:
            begin
               if (byte_done)
               begin
                  st_d = rtcp_pkg::st_ptr_ack;
               end
            end
            rtcp_pkg::st_ptr_ack:
            begin
               if (ack_end)
               begin
                  st_d = rtcp_pkg::st_wdata;
               end
            end
            rtcp_pkg::st_wdata:
            begin
               // any number of data bytes until the master stops
               if (byte_done)
               begin
                  st_d = rtcp_pkg::st_wdata_ack; // [R15]
               end
            end
            rtcp_pkg::st_wdata_ack:
            begin
               if (ack_end)
               begin
                  st_d = rtcp_pkg::st_wdata;
               end
            end
            rtcp_pkg::st_rdata:
            begin
               if (tx_done)
               begin
                  st_d = rtcp_pkg::st_rack;
               end
            end
            rtcp_pkg::st_rack:
            begin
               // not-acknowledge ends the read, acknowledge sends more
               if (m_nack)
               begin
                  st_d = rtcp_pkg::st_idle; // [R19] [R08]
               end
               else if (load_tx)
               begin
                  st_d = rtcp_pkg::st_rdata; // [R19]
               end
            end
            default:
            begin
               st_d = st_q;
            end
         endcase
      end
   end

   // slot phase and bit index restart on every state change or start
   always_comb
   begin
      ph_d = ph_q;
      bit_d = bit_q;
      if (start_det || (st_d != st_q))
      begin
         ph_d = 1'b0;
         bit_d = 3'h0; // [R20]
      end
      else
      begin
         if ((rtcp_pkg::rtcp_is_ack(st_q) && scl_fall) || m_ack)
         begin
            ph_d = 1'b1;
         end
         if (scl_rise)
         begin
            bit_d = bit_q + 3'h1;
         end
      end
   end

   // protocol state registers
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_q <= rtcp_pkg::st_idle;
         ph_q <= 1'b0;
         bit_q <= 3'h0;
      end
      else
      begin
         st_q <= st_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
      end
   end

   // receive shifter and direction bit
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sh_q <= 8'h00;
         dir_q <= rtcp_pkg::DIR_WRITE;
      end
      else
      begin
         if (rtcp_pkg::rtcp_is_rx(st_q) && scl_rise)
         begin
            sh_q <= byte_in; // [R09]
         end
         if (addr_hit)
         begin
            dir_q <= rx_bit; // [R12] [R16]
         end
      end
   end

   // register pointer; it survives transfers so a bare read resumes
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ptr_q <= rtcp_pkg::PTR_RST;
      end
      else if ((st_q == rtcp_pkg::st_ptr) && byte_done)
      begin
         // only the low bits address the 64-byte space
         ptr_q <= byte_in[5:0]; // [R13]
      end
      else if (wr_byte || tx_done)
      begin
         ptr_q <= rtcp_pkg::rtcp_ptr_next(ptr_q); // [R14] [R18] [R21]
      end
   end

   // accesses: a write per data byte, a fetch before each sent byte
   always_comb
   begin
      hs_req.we = wr_byte;
      hs_req.addr = ptr_q; // [R17]
      hs_req.wdata = wr_byte ? byte_in : 8'h00; // [R14]
      hs_valid = wr_byte || (addr_hit && rx_bit) || m_ack;
   end

   // one-word handshake into the system domain and back; a round
   // trip is far shorter than a bus half period at 100 kHz
   rtcp_hs_xfer u_xfer // [R03]
   (
      .i_rst_b(i_rst_b),
      .i_src_clock(i_link_clock),
      .i_src_valid(hs_valid),
      .i_src_req(hs_req),
      .o_src_busy(hs_busy),
      .o_src_done(),
      .o_src_rdata(rd_byte),
      .i_dst_clock(i_clock),
      .o_dst_valid(o_acc_valid),
      .o_dst_acc(o_acc),
      .i_dst_rdata(i_acc_rdata)
   );

   // transmit shifter, msb first
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         tx_q <= 8'h00;
      end
      else if (load_tx)
      begin
         tx_q <= {rd_byte[6:0], 1'b0}; // [R09]
      end
      else if ((st_q == rtcp_pkg::st_rdata) && scl_fall)
      begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // data line pull-down; it changes just after a clock fall, and is released at a start or stop
   always_ff @(posedge i_link_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         oe_q <= 1'b0;
      end
      else if (start_det || stop_det)
      begin
         oe_q <= 1'b0; // [R20]
      end
      else if (load_tx)
      begin
         oe_q <= ~rd_byte[7]; // [R17]
      end
      else if (rtcp_pkg::rtcp_is_ack(st_q) && scl_fall)
      begin
         // pull low over the whole ninth clock, then let go
         oe_q <= ~ph_q; // [R04] [R06]
      end
      else if ((st_q == rtcp_pkg::st_rdata) && scl_fall)
      begin
         oe_q <= ~tx_q[7]; // [R18]
      end
      else if ((st_q == rtcp_pkg::st_rack) && scl_fall)
      begin
         oe_q <= 1'b0; // [R07]
      end
   end

   // open drain: the value is always low, only the enable moves
   assign o_sda = 1'b0;
   assign o_sda_oe = oe_q;

   // the pull-down covers the ninth clock high phase
   chk_ack_held: assert property ( // [R06]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      (rtcp_pkg::rtcp_is_ack(st_q) && ph_q && scl_q[1]) |-> o_sda_oe)
      else $error("acknowledge not held low while clock high");

   // each own-address byte gets its acknowledge on the next fall
   chk_addr_acked: assert property ( // [R04]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      ((st_q == rtcp_pkg::st_addr_ack) && !ph_q && scl_fall) |=> o_sda_oe)
      else $error("address byte not acknowledged");

   // a start resets byte tracking and releases the line
   chk_start_reset: assert property ( // [R20]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      start_det |=> (st_q == rtcp_pkg::st_addr) && (bit_q == 3'h0) && !o_sda_oe)
      else $error("start did not reset the transfer");

   // a stop returns to idle with the line released
   chk_stop_idle: assert property ( // [R23]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      stop_det |=> (st_q == rtcp_pkg::st_idle) && !o_sda_oe)
      else $error("stop did not end the transfer");

   // a foreign address is left alone until the next start
   chk_foreign_quiet: assert property ( // [R24]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      (st_q == rtcp_pkg::st_idle) |-> !o_sda_oe)
      else $error("line driven while not addressed");

   // not-acknowledge ends the read with the line high
   chk_nack_release: assert property ( // [R19]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      m_nack |=> (st_q == rtcp_pkg::st_idle) ##1 !o_sda_oe)
      else $error("read not ended by not-acknowledge");

   // the word-address byte lands in the pointer
   chk_ptr_load: assert property ( // [R13]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      ((st_q == rtcp_pkg::st_ptr) && byte_done) |=> (ptr_q == $past(byte_in[5:0])))
      else $error("pointer not loaded from word address");

   // the pointer wraps at the top of the space
   chk_ptr_wrap: assert property ( // [R21]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      ((wr_byte || tx_done) && (ptr_q == rtcp_pkg::PTR_TOP))
      |=> (ptr_q == rtcp_pkg::PTR_FIRST))
      else $error("pointer did not wrap to zero");

   // each sent byte steps the pointer by one
   chk_read_step: assert property ( // [R18]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      (tx_done && (ptr_q != rtcp_pkg::PTR_TOP)) |=> (ptr_q == $past(ptr_q) + 6'h01))
      else $error("pointer did not advance after sent byte");

   // the first bit of a sent byte is its top bit
   chk_msb_first: assert property ( // [R09]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      load_tx |=> (o_sda_oe == !$past(rd_byte[7])))
      else $error("sent byte did not start with its top bit");

   // every fetch returns within one bus half period
   chk_fetch_time: assert property ( // [R17]
      @(posedge i_link_clock) disable iff (!i_rst_b)
      $rose(hs_busy) |-> ##[1:FETCH_MAX] !hs_busy)
      else $error("register access too slow for the bus");

endmodule

// [testbench/rtcp_i2c_master_model.sv]
`timescale 1ns/1ps
// behavioural bus master; the serial clock stands high between frames
module rtcp_i2c_master_model
#(
   parameter int QTR = 250 // quarter bit in system cycles, a 100 kHz bus
)
(
   // timing reference
   input wire logic i_clock,
   // resolved data line
   input wire logic i_sda,
   // master drive
   output logic o_scl,
   output logic o_sda_low
);

   // idle bus: both lines released to the pull-ups
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   // one quarter of a bit period
   task automatic qtr();
      repeat (QTR) @(posedge i_clock);
   endtask

   // start or repeated start; only the master makes it
   task automatic start();
      o_sda_low <= 1'b0;
      qtr();
      o_scl <= 1'b1;
      qtr();
      o_sda_low <= 1'b1;
      qtr();
      o_scl <= 1'b0;
      qtr();
   endtask

   // stop: data rises while the clock is high
   task automatic stop();
      o_sda_low <= 1'b1;
      qtr();
      o_scl <= 1'b1;
      qtr();
      o_sda_low <= 1'b0;
      qtr();
   endtask

   // one clock pulse: data changes only while the clock is low
   task automatic bit_cyc(input logic b, output logic r);
      o_sda_low <= !b;
      qtr();
      o_scl <= 1'b1;
      qtr();
      // sampled mid high phase, well clear of both edges
      r = i_sda;
      qtr();
      o_scl <= 1'b0;
      qtr();
   endtask

   // byte out msb first, then a released line for the ninth clock
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_cyc(d[i], r);
      end
      bit_cyc(1'b1, ack);
   endtask

   // byte in; acknowledge all but the last
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_cyc(1'b1, r);
         d[i] = r;
      end
      bit_cyc(last, r);
   endtask

endmodule

// [testbench/test_rtcp_i2c_slave.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("MISMATCH %0t got %h want %h", $time, (a), (b)); end end

module test_rtcp_i2c_slave;

   // clocks and reset
   logic i_clock = 1'b0;
   logic i_link_clock = 1'b0;
   logic i_rst_b = 1'b0;
   // bus lines
   logic scl;
   logic m_sda_low;
   logic sda_wire;
   // design outputs and register space answer
   logic o_sda;
   logic o_sda_oe;
   logic o_acc_valid;
   rtcp_pkg::rtcp_acc_t o_acc;
   rtcp_pkg::rtcp_acc_t exp_a;
   logic [7:0] i_acc_rdata;
   // register space model and notes of expected accesses
   logic [7:0] mem [64];
   rtcp_pkg::rtcp_acc_t exp_q [$];
   int fail_count = 0;
   int checks = 0;

   // system clock, 100 MHz
   always #5 i_clock = ~i_clock;

   // link clock offset so its edges never line up with the system clock
   initial
   begin
      #3.3;
      forever #15 i_link_clock = ~i_link_clock;
   end

   // open-drain data line with a pull-up
   assign sda_wire = (o_sda_oe ? o_sda : 1'b1) & !m_sda_low;
   // answered in the access cycle, as the port demands
   assign i_acc_rdata = mem[o_acc.addr];

   rtcp_i2c_slave dut (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_link_clock(i_link_clock),
      .i_scl(scl),
      .i_sda(sda_wire),
      .o_sda(o_sda),
      .o_sda_oe(o_sda_oe),
      .o_acc_valid(o_acc_valid),
      .o_acc(o_acc),
      .i_acc_rdata(i_acc_rdata)
   );

   rtcp_i2c_master_model master (
      .i_clock(i_clock),
      .i_sda(sda_wire),
      .o_scl(scl),
      .o_sda_low(m_sda_low)
   );

   // prints the counts and the verdict, then ends the run
   task automatic report_and_stop();
      $display("counts: checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog: a hung bus counts as a mismatch
   initial
   begin
      repeat (95000) @(posedge i_clock);
      fail_count++;
      report_and_stop();
   end

   // compares each register port access with the oldest note
   always @(posedge i_clock)
   begin
      if (o_acc_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            fail_count++;
            $display("MISMATCH %0t unexpected access", $time);
         end
         else
         begin
            exp_a = exp_q.pop_front();
            `CHK(o_acc.we, exp_a.we)
            `CHK(o_acc.addr, exp_a.addr)
            if (exp_a.we)
            begin
               `CHK(o_acc.wdata, exp_a.wdata)
               mem[o_acc.addr] <= o_acc.wdata;
            end
         end
      end
   end

   // main sequence
   initial
   begin
      logic ack;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [7:0] rd;
      void'($urandom(32'h2d2bdb08));
      for (int i = 0; i < 64; i++)
      begin
         mem[i] = 8'($urandom());
      end
      repeat (12) @(posedge i_clock);
      i_rst_b <= 1'b1;
      // lines idle for several link cycles before the first start
      repeat (20) @(posedge i_clock);

      // write at the top of ram; the second byte must wrap to zero
      d0 = 8'($urandom());
      d1 = 8'($urandom());
      exp_q.push_back({1'b1, 6'h3f, d0});
      exp_q.push_back({1'b1, 6'h00, d1});
      master.start();
      master.send({rtcp_pkg::DEV_ADDR, rtcp_pkg::DIR_WRITE}, ack);
      `CHK(ack, 1'b0)
      `CHK(o_sda, 1'b0)
      // upper pointer bits are ignored, so this selects the top byte
      master.send(8'hff, ack);
      `CHK(ack, 1'b0)
      master.send(d0, ack);
      `CHK(ack, 1'b0)
      master.send(d1, ack);
      `CHK(ack, 1'b0)
      master.stop();
      `CHK(exp_q.size(), 0)
      $display("test write with pointer wrap done");

      // foreign address ignored, then a repeated start into a read
      exp_q.push_back({1'b0, 6'h01, 8'h00});
      exp_q.push_back({1'b0, 6'h02, 8'h00});
      master.start();
      master.send({rtcp_pkg::DEV_ADDR ^ 7'h01, rtcp_pkg::DIR_READ}, ack);
      `CHK(ack, 1'b1)
      `CHK(exp_q.size(), 2)
      master.start();
      master.send({rtcp_pkg::DEV_ADDR, rtcp_pkg::DIR_READ}, ack);
      `CHK(ack, 1'b0)
      // no pointer write here: the read continues after the wrap
      master.recv(1'b0, rd);
      `CHK(rd, mem[1])
      master.recv(1'b1, rd);
      `CHK(rd, mem[2])
      `CHK(o_sda_oe, 1'b0)
      `CHK(sda_wire, 1'b1)
      master.stop();
      `CHK(exp_q.size(), 0)
      $display("test repeated start read done");
      report_and_stop();
   end

endmodule
